// file: src/adc_result_regs.vh
`ifndef ADC_RESULT_REGS_VH
`define ADC_RESULT_REGS_VH

// Register offsets in I/O space
`define RESULT_LOW_BYTE_OFFSET    8'h04
`define RESULT_HIGH_BYTE_OFFSET   8'h05
// Added to an I/O offset for data-space access
`define DATA_SPACE_OFFSET         8'h20
// Reset values
`define RESULT_LOW_BYTE_RESET     8'h00
`define RESULT_HIGH_BYTE_RESET    8'h00
`define RESULT_RESET              10'h000
// Answer to an unmapped read
`define UNMAPPED_READ_VALUE       8'h00
// Converter clock cycles per conversion
`define NORMAL_CONVERSION_CYCLES  5'h0d
`define FIRST_CONVERSION_CYCLES   5'h19
// Result field positions, left aligned
`define LEFT_LOW_SHIFT            6
`define LEFT_HIGH_SHIFT           2

`endif

// file: src/converter_clock_prescaler.v
`timescale 1ns/1ns
`include "adc_result_regs.vh"

module converter_clock_prescaler
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       sys_rst_i,
	// Control
	input  wire       run_i,
	input  wire [2:0] converter_clock_divide_select_i,
	// Converter clock
	output wire       converter_clk_o,
	output wire       converter_tick_o
);

	reg  [5:0] count_reg;
	reg  [5:0] count_next;
	reg        clk_level_reg;
	reg        clk_level_next;
	reg  [5:0] half_period;
	wire       half_done;

	// Half period in system clocks, minus one
	always @*
	begin
		case (converter_clock_divide_select_i)
			3'h0, 3'h1: half_period = 6'h00;
			3'h2:       half_period = 6'h01;
			3'h3:       half_period = 6'h03;
			3'h4:       half_period = 6'h07;
			3'h5:       half_period = 6'h0f;
			3'h6:       half_period = 6'h1f;
			3'h7:       half_period = 6'h3f;
			default:    half_period = 6'h00;
		endcase
	end

	assign half_done = (count_reg >= half_period);

	always @*
	begin
		count_next     = count_reg;
		clk_level_next = clk_level_reg;
		if (!run_i)
		begin
			count_next     = 6'h00;
			clk_level_next = 1'b0;
		end
		else if (half_done)
		begin
			count_next     = 6'h00;
			clk_level_next = ~clk_level_reg;
		end
		else
			count_next = count_reg + 6'h01;
	end

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			count_reg     <= 6'h00;
			clk_level_reg <= 1'b0;
		end
		else
		begin
			count_reg     <= count_next;
			clk_level_reg <= clk_level_next;
		end
	end

	// One pulse per converter clock rising edge
	assign converter_tick_o = run_i & half_done & ~clk_level_reg;
	assign converter_clk_o  = clk_level_reg;

endmodule // converter_clock_prescaler

// file: src/adc_result_and_prescaler.v
`timescale 1ns/1ns
`include "adc_result_regs.vh"

module adc_result_and_prescaler
(
	// Clock and reset
	input  wire       clk_i,
	input  wire       sys_rst_i,
	// Processor register port
	input  wire [7:0] reg_addr_i,
	input  wire       data_space_i,
	input  wire       reg_read_i,
	input  wire       reg_write_i,
	input  wire [7:0] reg_wdata_i,
	output wire [7:0] reg_rdata_o,
	// Converter control
	input  wire       converter_enable_i,
	input  wire       start_conversion_i,
	input  wire       free_running_i,
	input  wire [2:0] converter_clock_divide_select_i,
	input  wire       left_align_select_i,
	input  wire       conversion_done_clear_i,
	// Analog converter side
	input  wire [9:0] result_bits_i,
	output wire       converter_clk_o,
	// Status
	output wire       conversion_busy_o,
	output wire       conversion_done_flag_o,
	output wire       result_locked_o
);

	localparam ST_IDLE    = 1'b0;
	localparam ST_CONVERT = 1'b1;

	// Register address match for I/O or data-space access
	function addr_hit;
		input [7:0] addr;
		input       data_space;
		input [7:0] offset;
		begin
			if (data_space)
				addr_hit = (addr == offset + `DATA_SPACE_OFFSET);
			else
				addr_hit = (addr == offset);
		end
	endfunction

	// Presented byte of the stored result
	function [7:0] present_byte;
		input [9:0] result;
		input       left;
		input       high;
		begin
			if (left && high)
				present_byte = result[9:`LEFT_HIGH_SHIFT];
			else if (left)
				present_byte = {result[1:0], 6'h00};
			else if (high)
				present_byte = {6'h00, result[9:8]};
			else
				present_byte = result[7:0];
		end
	endfunction

	reg  [9:0] sample_meta_reg;
	reg  [9:0] sample_sync_reg;
	reg        state_reg;
	reg        state_next;
	reg  [4:0] cycle_count_reg;
	reg  [4:0] cycle_count_next;
	reg  [4:0] cycle_target_reg;
	reg  [4:0] cycle_target_next;
	reg        first_pending_reg;
	reg        first_pending_next;
	reg        enable_seen_reg;
	reg  [9:0] result_reg;
	reg  [9:0] result_next;
	reg        lock_reg;
	reg        lock_next;
	reg        done_flag_reg;
	reg        done_flag_next;
	reg  [7:0] rdata_reg;
	reg  [7:0] rdata_next;
	reg        finish;
	wire       converter_tick;
	wire       low_hit;
	wire       high_hit;

	converter_clock_prescaler u_prescaler
	(
		.clk_i                           (clk_i),
		.sys_rst_i                       (sys_rst_i),
		.run_i                           (converter_enable_i),
		.converter_clock_divide_select_i (converter_clock_divide_select_i),
		.converter_clk_o                 (converter_clk_o),
		.converter_tick_o                (converter_tick)
	);

	assign low_hit  = addr_hit(reg_addr_i, data_space_i,
	                           `RESULT_LOW_BYTE_OFFSET);
	assign high_hit = addr_hit(reg_addr_i, data_space_i,
	                           `RESULT_HIGH_BYTE_OFFSET);

	// Conversion sequencer
	always @*
	begin
		state_next         = state_reg;
		cycle_count_next   = cycle_count_reg;
		cycle_target_next  = cycle_target_reg;
		first_pending_next = first_pending_reg;
		finish             = 1'b0;
		if (converter_enable_i && !enable_seen_reg)
			first_pending_next = 1'b1;
		case (state_reg)
			ST_IDLE:
			begin
				if (converter_enable_i && start_conversion_i)
				begin
					state_next       = ST_CONVERT;
					cycle_count_next = 5'h00;
					if (first_pending_next)
						cycle_target_next = `FIRST_CONVERSION_CYCLES;
					else
						cycle_target_next = `NORMAL_CONVERSION_CYCLES;
					first_pending_next = 1'b0;
				end
			end
			ST_CONVERT:
			begin
				if (!converter_enable_i)
					state_next = ST_IDLE;
				else if (converter_tick)
				begin
					if (cycle_count_reg == cycle_target_reg - 5'h01)
					begin
						finish           = 1'b1;
						cycle_count_next = 5'h00;
						cycle_target_next = `NORMAL_CONVERSION_CYCLES;
						if (!free_running_i)
							state_next = ST_IDLE;
					end
					else
						cycle_count_next = cycle_count_reg + 5'h01;
				end
			end
			default:
				state_next = ST_IDLE;
		endcase
	end

	// Result store, lock and done flag
	always @*
	begin
		result_next    = result_reg;
		lock_next      = lock_reg;
		done_flag_next = done_flag_reg;
		rdata_next     = `UNMAPPED_READ_VALUE;
		if (reg_read_i && low_hit)
		begin
			rdata_next = present_byte(result_reg, left_align_select_i,
			                          1'b0);
			lock_next  = 1'b1;
		end
		else if (reg_read_i && high_hit)
		begin
			rdata_next = present_byte(result_reg, left_align_select_i,
			                          1'b1);
			lock_next  = 1'b0;
		end
		if (conversion_done_clear_i)
			done_flag_next = 1'b0;
		if (finish)
		begin
			done_flag_next = 1'b1;
			if (!lock_reg)
				result_next = sample_sync_reg;
		end
		// Locked results keep their value, new result is lost
	end

	always @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			sample_meta_reg   <= `RESULT_RESET;
			sample_sync_reg   <= `RESULT_RESET;
			state_reg         <= ST_IDLE;
			cycle_count_reg   <= 5'h00;
			cycle_target_reg  <= `NORMAL_CONVERSION_CYCLES;
			first_pending_reg <= 1'b0;
			enable_seen_reg   <= 1'b0;
			result_reg        <= `RESULT_RESET;
			lock_reg          <= 1'b0;
			done_flag_reg     <= 1'b0;
			rdata_reg         <= `UNMAPPED_READ_VALUE;
		end
		else
		begin
			sample_meta_reg   <= result_bits_i;
			sample_sync_reg   <= sample_meta_reg;
			state_reg         <= state_next;
			cycle_count_reg   <= cycle_count_next;
			cycle_target_reg  <= cycle_target_next;
			first_pending_reg <= first_pending_next & converter_enable_i;
			enable_seen_reg   <= converter_enable_i;
			result_reg        <= result_next;
			lock_reg          <= lock_next;
			done_flag_reg     <= done_flag_next;
			rdata_reg         <= rdata_next;
		end
	end

	// Writes are ignored: result bytes are read-only
	assign reg_rdata_o            = rdata_reg;
	assign conversion_busy_o      = (state_reg == ST_CONVERT);
	assign conversion_done_flag_o = done_flag_reg;
	assign result_locked_o        = lock_reg;

endmodule // adc_result_and_prescaler

// file: bench/adc_result_and_prescaler_monitor.sv
`timescale 1ns/1ns
module adc_result_and_prescaler_monitor
(
	// Clock and reset
	input wire		clk_i,
	input wire		sys_rst_i,
	// Register port
	input wire [7:0]	reg_addr_i,
	input wire		data_space_i,
	input wire		reg_read_i,
	input wire [7:0]	reg_rdata_o,
	// Converter
	input wire		converter_enable_i,
	input wire		start_conversion_i,
	input wire		left_align_select_i,
	input wire		conversion_done_clear_i,
	input wire		converter_clk_o,
	input wire		conversion_busy_o,
	input wire		conversion_done_flag_o,
	input wire		result_locked_o
);
	wire	rd_lo = reg_read_i && reg_addr_i == 8'h04 && !data_space_i;
	wire	rd_hi = reg_read_i && reg_addr_i == 8'h05 && !data_space_i;
	reg [11:0]	lock_age;
	// Cycles spent locked, saturating
	always @(posedge clk_i)
	begin
		if (sys_rst_i || !result_locked_o)
			lock_age <= 12'h000;
		else if (lock_age != 12'hfff)
			lock_age <= lock_age + 12'h001;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	lock_set_a: assert property (rd_lo |=> result_locked_o)
		else $error("low read did not lock");
	lock_clear_a: assert property (rd_hi |=> !result_locked_o)
		else $error("high read did not unlock");
	right_high_a: assert property (rd_hi && !left_align_select_i
		|=> reg_rdata_o[7:2] == 6'h00)
		else $error("right high byte has upper bits");
	left_low_a: assert property (rd_lo && left_align_select_i
		|=> reg_rdata_o[5:0] == 6'h00)
		else $error("left low byte has lower bits");
	clk_off_a: assert property (!converter_enable_i |=> !converter_clk_o)
		else $error("converter clock runs while off");
	busy_start_a: assert property (converter_enable_i && start_conversion_i
		&& !conversion_busy_o |=> conversion_busy_o)
		else $error("start did not set busy");
	busy_min_a: assert property ($rose(conversion_busy_o) |->
		(conversion_busy_o || !$past(converter_enable_i))[*8])
		else $error("conversion too short");
	done_hold_a: assert property (conversion_done_flag_o
		&& !conversion_done_clear_i |=> conversion_done_flag_o)
		else $error("done flag dropped");
	cover property (rd_hi && result_locked_o && lock_age < 12'hfa0);
	cover property ($rose(conversion_done_flag_o));
	cover property (rd_hi && left_align_select_i);
endmodule // adc_result_and_prescaler_monitor

bind adc_result_and_prescaler adc_result_and_prescaler_monitor u_mon (.*);

// file: bench/test_adc_result_and_prescaler.sv
`timescale 1ns/1ns
module test_adc_result_and_prescaler;
	reg		clk_i = 0;
	reg		sys_rst_i = 1;
	reg [7:0]	reg_addr_i = 8'h00;
	reg		data_space_i = 0;
	reg		reg_read_i = 0;
	reg		reg_write_i = 0;
	reg [7:0]	reg_wdata_i = 8'h00;
	reg		converter_enable_i = 0;
	reg		start_conversion_i = 0;
	reg		free_running_i = 0;
	reg [2:0]	converter_clock_divide_select_i = 3'h0;
	reg		left_align_select_i = 0;
	reg		conversion_done_clear_i = 0;
	reg [9:0]	result_bits_i = 10'h000;
	wire [7:0]	reg_rdata_o;
	wire		converter_clk_o, conversion_busy_o;
	wire		conversion_done_flag_o, result_locked_o;
	integer		n_mismatch = 0;
	integer		comparisons = 0;
	integer		i;
	reg [9:0]	v, w;
	reg [7:0]	d;

	adc_result_and_prescaler u_dut (.*);

	initial forever #2 clk_i = ~clk_i;

	task results;
	begin
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask

	task chk(input [63:0] nm, input [7:0] s, input [7:0] e);
	begin
		comparisons = comparisons + 1;
		if (s !== e)
		begin
			n_mismatch = n_mismatch + 1;
			$display("wrong value %0s expected %h seen %h", nm, e, s);
		end
	end
	endtask

	task rd(input [7:0] a, input ds, output [7:0] q);
	begin
		@(negedge clk_i);
		reg_addr_i = a + (ds ? 8'h20 : 8'h00);
		data_space_i = ds;
		reg_read_i = 1;
		@(negedge clk_i);
		reg_read_i = 0;
		q = reg_rdata_o;
	end
	endtask

	task rc(input [63:0] nm, input [7:0] a, input ds, input [7:0] e);
		reg [7:0] q;
	begin
		rd(a, ds, q);
		chk(nm, q, e);
	end
	endtask

	task conv(input [9:0] r, input [2:0] code, input integer ticks);
		integer n, f;
	begin
		f = (code < 2) ? 2 : (1 << code);
		@(negedge clk_i);
		result_bits_i = r;
		converter_clock_divide_select_i = code;
		start_conversion_i = 1;
		n = 0;
		@(negedge clk_i);
		start_conversion_i = 0;
		while (conversion_done_flag_o !== 1'b1 && n < 40000)
		begin
			@(negedge clk_i);
			n = n + 1;
		end
		if (n >= 40000)
		begin
			n_mismatch = n_mismatch + 1;
			results;
		end
		chk("cycles", n > (ticks - 1) * f && n <= ticks * f, 1);
		conversion_done_clear_i = 1;
		@(negedge clk_i);
		conversion_done_clear_i = 0;
	end
	endtask

	initial
	begin
		repeat (12) @(negedge clk_i);
		sys_rst_i = 0;
		reg_addr_i = 8'h04;
		reg_wdata_i = 8'hff;
		reg_write_i = 1;
		@(negedge clk_i);
		reg_write_i = 0;
		for (i = 0; i < 5; i = i + 1)
			rc("reset", i < 4 ? 8'h04 + i[0] : 8'h06, i[1], 8'h00);
		converter_enable_i = 1;
		conv(10'h2a5, 3'h0, 25);
		for (i = 0; i < 8; i = i + 1)
		begin
			v = 10'h15a + i * 10'h0c7;
			conv(v, i, 13);
			left_align_select_i = 0;
			rc("rlow", 8'h04, i[0], v[7:0]);
			rc("rhigh", 8'h05, i[0], {6'h00, v[9:8]});
			left_align_select_i = 1;
			rc("llow", 8'h04, i[0], {v[1:0], 6'h00});
			rc("lhigh", 8'h05, i[0], v[9:2]);
			left_align_select_i = 0;
		end
		w = ~v;
		rd(8'h04, 0, d);
		chk("lockbit", result_locked_o, 1);
		conv(w, 3'h1, 13);
		rc("locked", 8'h05, 0, {6'h00, v[9:8]});
		rc("kept", 8'h04, 0, v[7:0]);
		rc("unlock", 8'h05, 0, {6'h00, v[9:8]});
		conv(w, 3'h1, 13);
		rc("new", 8'h04, 0, w[7:0]);
		rc("newhigh", 8'h05, 0, {6'h00, w[9:8]});
		free_running_i = 1;
		conv(w, 3'h1, 13);
		chk("frbusy", conversion_busy_o, 1);
		result_bits_i = v;
		free_running_i = 0;
		i = 0;
		while (conversion_done_flag_o !== 1'b1 && i < 400)
		begin
			@(negedge clk_i);
			i = i + 1;
		end
		chk("frcycles", i > 21 && i <= 26, 1);
		if (i >= 400)
			results;
		chk("frbusy", conversion_busy_o, 0);
		rc("frhigh", 8'h05, 0, {6'h00, v[9:8]});
		chk("unlocked", result_locked_o, 0);
		sys_rst_i = 1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 0;
		chk("rstflag", conversion_done_flag_o, 0);
		rc("reset2", 8'h04, 0, 8'h00);
		results;
	end
endmodule // test_adc_result_and_prescaler
